// file: sdwa_top.sv
// word-aligning serdes core: serializer, comma aligner, byte clocks, test pattern, registers
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module sdwa_top
(
   input  wire logic                        clk_i,
   input  wire logic                        resetn_i,
   input  wire logic [sdwa_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic                        s_axi_awvalid_i,
   output logic                             s_axi_awready_o,
   input  wire logic [sdwa_pkg::DATA_W-1:0] s_axi_wdata_i,
   input  wire logic [3:0]                  s_axi_wstrb_i,
   input  wire logic                        s_axi_wvalid_i,
   output logic                             s_axi_wready_o,
   output logic [1:0]                       s_axi_bresp_o,
   output logic                             s_axi_bvalid_o,
   input  wire logic                        s_axi_bready_i,
   input  wire logic [sdwa_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic                        s_axi_arvalid_i,
   output logic                             s_axi_arready_o,
   output logic [sdwa_pkg::DATA_W-1:0]      s_axi_rdata_o,
   output logic [1:0]                       s_axi_rresp_o,
   output logic                             s_axi_rvalid_o,
   input  wire logic                        s_axi_rready_i,
   input  wire logic [sdwa_pkg::WORD_W-1:0] tx_parallel_word_i,
   output logic                             tx_ref_clock_o,
   output logic                             serial_out_o,
   input  wire logic                        serial_in_pos_i,
   input  wire logic                        serial_in_neg_i,
   output logic [sdwa_pkg::WORD_W-1:0]      rx_parallel_word_o,
   output logic                             rx_byte_clock_a_o,
   output logic                             rx_byte_clock_b_o,
   output logic                             sync_pass_o
);
   import sdwa_pkg::*;

   //=======================================================================
   // declarations
   logic              align_enable;
   logic              pattern_test_enable;
   logic [15:0]       comma_count;
   logic              wr_go;
   logic              wr_hs;
   logic              rd_go;
   logic              rd_hs;
   logic [CNT_W-1:0]  tx_div;
   logic [CNT_W-1:0]  next_tx_div;
   logic              tx_load;
   logic [WORD_W-1:0] tx_hold;
   logic [WORD_W-1:0] tx_shift;
   logic [WORD_W-1:0] gen_word;
   logic              gen_bit;
   logic              rx_bit;
   logic [WORD_W-1:0] rx_shift;
   logic [CNT_W-1:0]  rx_cnt;
   logic              comma_hit;
   logic              realign;
   logic              word_done;
   logic [WORD_W-1:0] rx_stage;
   logic              stage_comma;
   logic              sync_word;
   logic              next_sync_word;
   logic [4:0]        half_bits;
   logic              clk_toggle;
   logic              chk_err;
   logic              pass;
   sdwa_align_t       align_state;
   sdwa_align_t       next_align_state;

   //=======================================================================
   // axi4-lite write channel: address and data taken together
   assign wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_awready_o && !s_axi_bvalid_o;
   assign wr_hs = s_axi_awready_o && s_axi_awvalid_i && s_axi_wvalid_i;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
      end
      else
      begin
         s_axi_awready_o <= wr_go;
         s_axi_wready_o  <= wr_go;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= RESP_OKAY;
      end
      else if (wr_hs)
      begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= (s_axi_awaddr_i == CTRL_OFS) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_i)
      begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // control bits steer alignment and the test pattern
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         align_enable        <= ALIGN_RESET;
         pattern_test_enable <= PRBS_RESET;
      end
      else if (wr_hs && (s_axi_awaddr_i == CTRL_OFS) && s_axi_wstrb_i[0])
      begin
         align_enable        <= s_axi_wdata_i[CTRL_ALIGN];
         pattern_test_enable <= s_axi_wdata_i[CTRL_PRBS];
      end
   end

   //=======================================================================
   // axi4-lite read channel
   assign rd_go = s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o;
   assign rd_hs = s_axi_arready_o && s_axi_arvalid_i;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         s_axi_arready_o <= 1'b0;
      else
         s_axi_arready_o <= rd_go;
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= RESP_OKAY;
      end
      else if (rd_hs)
      begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rresp_o  <= RESP_OKAY;
         case (s_axi_araddr_i)
            CTRL_OFS:
               s_axi_rdata_o <= {30'h0, pattern_test_enable, align_enable};
            STAT_OFS:
               s_axi_rdata_o <= {28'h000_0000, sync_pass_o, align_state, pass};
            COUNT_OFS:
               s_axi_rdata_o <= {16'h0000, comma_count};
            default:
            begin
               s_axi_rdata_o <= 32'h0000_0000;
               s_axi_rresp_o <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready_i)
      begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   //=======================================================================
   // transmit: reference clock divided from the bit clock
   assign next_tx_div = (tx_div == WORD_LAST) ? 4'h0 : tx_div + 4'h1;
   assign tx_load     = (tx_div == WORD_LAST);

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         tx_div         <= 4'h0;
         tx_ref_clock_o <= 1'b0;
      end
      else
      begin
         tx_div         <= next_tx_div;
         tx_ref_clock_o <= (next_tx_div < REF_HIGH_CNT);
      end
   end

   sdwa_prbs7
   #(
      .CHECK (1'b0)
   )
   u_gen
   (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .enable_i (pattern_test_enable),
      .bit_i    (1'b0),
      .bit_o    (gen_bit),
      .error_o  ()
   );

   // generator bits gathered into words, oldest bit lands in bit 0
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         gen_word <= 10'h000;
      else
         gen_word <= {gen_bit, gen_word[WORD_W-1:1]};
   end

   // a holding stage gives 20 bit times from load to bit 9 on the line
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         tx_hold  <= 10'h000;
         tx_shift <= 10'h000;
      end
      else if (tx_load)
      begin
         tx_hold  <= pattern_test_enable ? gen_word : tx_parallel_word_i;
         tx_shift <= tx_hold;
      end
      else
      begin
         tx_shift <= {1'b0, tx_shift[WORD_W-1:1]};
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         serial_out_o <= 1'b0;
      else
         serial_out_o <= tx_shift[0];
   end

   //=======================================================================
   // receive: bits sampled straight off the line, no reference preset needed
   assign rx_bit = serial_in_pos_i & ~serial_in_neg_i;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rx_shift <= 10'h000;
      else
         rx_shift <= {rx_bit, rx_shift[WORD_W-1:1]};
   end

   // checked every bit, so every one of the ten offsets is seen
   assign comma_hit = (rx_shift[WORD_W-1:3] == COMMA);
   assign realign   = align_enable && comma_hit && (rx_cnt != COMMA_END_POS);
   assign word_done = (rx_cnt == WORD_LAST) && !realign;

   // a jump drops the partial word; unframed counting when disabled
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rx_cnt <= 4'h0;
      else if (realign)
         rx_cnt <= REALIGN_POS;
      else if (rx_cnt == WORD_LAST)
         rx_cnt <= 4'h0;
      else
         rx_cnt <= rx_cnt + 4'h1;
   end

   // one word of look-ahead lets the byte clocks steer the comma onto clock b
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rx_stage           <= 10'h000;
         stage_comma        <= 1'b0;
         rx_parallel_word_o <= 10'h000;
      end
      else if (word_done)
      begin
         rx_stage           <= rx_shift;
         stage_comma        <= (rx_shift[6:0] == COMMA);
         rx_parallel_word_o <= rx_stage;
      end
   end

   //=======================================================================
   // alignment state
   always_comb
   begin
      next_align_state = align_state;
      case (align_state)
         AL_FREE:
            if (align_enable)
               next_align_state = AL_HUNT;
         AL_HUNT:
            if (!align_enable)
               next_align_state = AL_FREE;
            else if (comma_hit)
               next_align_state = AL_LOCK;
         AL_LOCK:
            if (!align_enable)
               next_align_state = AL_FREE;
            else if (realign)
               next_align_state = AL_HUNT;
         default:
            next_align_state = AL_FREE;
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         align_state <= AL_FREE;
      else
         align_state <= next_align_state;
   end

   //=======================================================================
   // byte clocks: toggle mid-word, never before a full half period
   assign clk_toggle = (rx_cnt == CLK_MID_POS) && (half_bits >= MIN_HALF_BITS)
                       && !(align_enable && stage_comma && !rx_byte_clock_b_o);

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         half_bits <= 5'h00;
      else if (clk_toggle)
         half_bits <= 5'h00;
      else if (half_bits < MIN_HALF_BITS)
         half_bits <= half_bits + 5'h01;
   end

   // clock b rises on words 0 and 2, clock a on words 1 and 3
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rx_byte_clock_a_o <= 1'b1;
         rx_byte_clock_b_o <= 1'b0;
      end
      else if (clk_toggle)
      begin
         rx_byte_clock_a_o <= rx_byte_clock_b_o;
         rx_byte_clock_b_o <= ~rx_byte_clock_b_o;
      end
   end

   //=======================================================================
   // sync pulse and comma count
   assign next_sync_word = word_done ? (align_enable && stage_comma) : sync_word;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         sync_word <= 1'b0;
      else
         sync_word <= next_sync_word;
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         comma_count <= 16'h0000;
      else if (word_done && align_enable && stage_comma)
         comma_count <= comma_count + 16'h0001;
   end

   //=======================================================================
   // pattern checker and pass flag
   sdwa_prbs7
   #(
      .CHECK (1'b1)
   )
   u_chk
   (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .enable_i (pattern_test_enable),
      .bit_i    (rx_bit),
      .bit_o    (),
      .error_o  (chk_err)
   );

   // latched mode holds a failure until the test or alignment is switched off
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         pass <= 1'b1;
      else if (!pattern_test_enable)
         pass <= 1'b1;
      else if (align_enable)
         pass <= pass && !chk_err;
      else
         pass <= !chk_err;
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         sync_pass_o <= 1'b0;
      else if (pattern_test_enable)
         sync_pass_o <= pass;
      else
         sync_pass_o <= next_sync_word;
   end
endmodule

// file: sdwa_pkg.sv
// constants, types and encodings shared by the word-aligning serdes
//==========================================================================
package sdwa_pkg;
   //=======================================================================
   // word and bit timing, one clk_i cycle per serial bit
   localparam int         WORD_W        = 10;
   localparam int         CNT_W         = 4;
   localparam logic [3:0] WORD_LAST     = 4'h9;
   localparam logic [3:0] REF_HIGH_CNT  = 4'h5;
   localparam logic [3:0] CLK_MID_POS   = 4'h4;
   localparam logic [3:0] COMMA_END_POS = 4'h6;
   localparam logic [3:0] REALIGN_POS   = 4'h7;
   localparam logic [4:0] MIN_HALF_BITS = 5'h09;
   //=======================================================================
   // line code constants, bit 0 is the first bit on the line
   localparam logic [9:0] K28_5_NEG     = 10'h17C;
   localparam logic [6:0] COMMA         = K28_5_NEG[6:0];
   localparam logic [6:0] PRBS_SEED     = 7'h7F;
   localparam logic [2:0] PRBS_SETTLE   = 3'h7;
   //=======================================================================
   // register map
   localparam int         ADDR_W        = 4;
   localparam int         DATA_W        = 32;
   localparam logic [3:0] CTRL_OFS      = 4'h0;
   localparam logic [3:0] STAT_OFS      = 4'h4;
   localparam logic [3:0] COUNT_OFS     = 4'h8;
   localparam int         CTRL_ALIGN    = 0;
   localparam int         CTRL_PRBS     = 1;
   localparam logic       ALIGN_RESET   = 1'b1;
   localparam logic       PRBS_RESET    = 1'b0;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
   //=======================================================================
   // alignment state, gray coded along free -> hunt -> lock
   typedef enum logic [1:0]
   {
      AL_FREE = 2'h0,
      AL_HUNT = 2'h1,
      AL_LOCK = 2'h3
   } sdwa_align_t;
endpackage

// file: sdwa_prbs7.sv
// seven-stage pseudo-random generator or self-synchronizing checker
`timescale 1ns/1ps
module sdwa_prbs7
#(
   parameter bit CHECK = 1'b0
)
(
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic enable_i,
   input  wire logic bit_i,
   output logic      bit_o,
   output logic      error_o
);
   import sdwa_pkg::*;

   logic [6:0] state;
   logic [2:0] settle;
   logic       fb;

   assign fb    = state[6] ^ state[5];
   assign bit_o = fb;

   // checker shifts in line bits, so it locks to any phase of the sequence
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         state <= PRBS_SEED;
      else if (!enable_i)
         state <= PRBS_SEED;
      else
         state <= {state[5:0], (CHECK ? bit_i : fb)};
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         settle <= 3'h0;
      else if (!enable_i)
         settle <= 3'h0;
      else if (settle != PRBS_SETTLE)
         settle <= settle + 3'h1;
   end

   // no error until seven line bits have filled the predictor
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         error_o <= 1'b0;
      else
         error_o <= CHECK && enable_i && (settle == PRBS_SETTLE) && (bit_i != fb);
   end
endmodule

// file: sdwa_asserts.sv
// concurrent checks on the word-aligning serdes top-level ports
`timescale 1ns/1ps
module sdwa_asserts
(
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic [3:0]  s_axi_awaddr_i,
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0]  s_axi_wstrb_i,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic [9:0]  tx_parallel_word_i,
   input wire logic        tx_ref_clock_o,
   input wire logic        serial_out_o,
   input wire logic [9:0]  rx_parallel_word_o,
   input wire logic        rx_byte_clock_a_o,
   input wire logic        rx_byte_clock_b_o,
   input wire logic        sync_pass_o
);
   import sdwa_pkg::*;
   //=======================================================================
   // control shadow, rebuilt from observed register writes
   logic       al_en;
   logic       ts_en;
   logic       wr_ok;
   logic [1:0] rises;
   logic       clk_a_q;
   logic [4:0] a_age;
   logic [9:0] word_q;
   logic [3:0] sync_run;
   assign wr_ok = s_axi_awvalid_i & s_axi_awready_o & s_axi_wvalid_i & s_axi_wready_o
                  & (s_axi_awaddr_i == CTRL_OFS) & s_axi_wstrb_i[0];
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         al_en <= ALIGN_RESET;
         ts_en <= PRBS_RESET;
      end
      else if (wr_ok)
      begin
         al_en <= s_axi_wdata_i[CTRL_ALIGN];
         ts_en <= s_axi_wdata_i[CTRL_PRBS];
      end
   // first reference rises carry words captured around reset, so skip them
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
         rises <= 2'h0;
      else if ($rose(tx_ref_clock_o) && rises != 2'h3)
         rises <= rises + 2'h1;
   // age of the clock a level, and run length of a sync pulse over one steady word
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         clk_a_q  <= 1'b1;
         a_age    <= 5'h00;
         word_q   <= 10'h000;
         sync_run <= 4'h0;
      end
      else
      begin
         clk_a_q <= rx_byte_clock_a_o;
         word_q  <= rx_parallel_word_o;
         if (rx_byte_clock_a_o != clk_a_q)
            a_age <= 5'h01;
         else if (a_age != 5'h1F)
            a_age <= a_age + 5'h01;
         if (!sync_pass_o)
            sync_run <= 4'h0;
         else if (rx_parallel_word_o != word_q)
            sync_run <= 4'h1;
         else if (sync_run != 4'hF)
            sync_run <= sync_run + 4'h1;
      end
   //=======================================================================
   // properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   a_tx_bit_first: assert property (
      $rose(tx_ref_clock_o) && rises == 2'h3 && !$past(ts_en) |-> ##11
      ts_en || serial_out_o == $past(tx_parallel_word_i[0], 12)) else $error("tx bit 0 wrong");
   a_tx_bit_last: assert property (
      $rose(tx_ref_clock_o) && rises == 2'h3 && !$past(ts_en) |-> ##20
      ts_en || serial_out_o == $past(tx_parallel_word_i[9], 21)) else $error("tx bit 9 wrong");
   a_clk_anti: assert property (
      rx_byte_clock_a_o != rx_byte_clock_b_o) else $error("byte clocks not in antiphase");
   a_clk_min_half: assert property (
      $changed(rx_byte_clock_a_o) |-> a_age >= 5'h0A) else $error("pulse shortened");
   a_clk_max_half: assert property (
      $changed(rx_byte_clock_a_o) |-> ##[1:30] $changed(rx_byte_clock_a_o))
      else $error("pulse stretched too far");
   a_sync_word: assert property (
      sync_pass_o && !ts_en && !$past(ts_en, 12) |-> rx_parallel_word_o[6:0] == COMMA)
      else $error("sync without comma word");
   a_sync_len: assert property (
      $rose(sync_pass_o) && !ts_en && !$past(ts_en, 12)
      |-> ##10 sync_run == 4'hA) else $error("sync pulse too short");
   a_sync_on_b: assert property (
      $rose(sync_pass_o) && al_en && !ts_en && !$past(ts_en, 12) |-> ##5 $rose(rx_byte_clock_b_o))
      else $error("comma word not on clock b rise");
   a_sync_gate: assert property (
      sync_pass_o && !ts_en && !$past(ts_en, 12) |-> al_en || $past(al_en, 11))
      else $error("sync while alignment off");
   a_pass_latch: assert property (
      ts_en && al_en && $past(ts_en, 12) && !sync_pass_o |=> !sync_pass_o || !ts_en || !al_en)
      else $error("failure not latched");
   c_sync: cover property ($rose(sync_pass_o) && !ts_en);
   c_fail: cover property (ts_en && al_en && $fell(sync_pass_o));
   c_ctrl: cover property (wr_ok);
endmodule
bind sdwa_top sdwa_asserts u_sdwa_asserts (.*);

// file: sdwa_mac_model.sv
// protocol controller model: feeds transmit words, captures receive words
`timescale 1ns/1ps
module sdwa_mac_model
(
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       tx_ref_clock_i,
   input  wire logic [9:0] rx_word_i,
   input  wire logic       rx_clock_a_i,
   input  wire logic       rx_clock_b_i,
   output logic [9:0]      tx_word_o,
   output logic [15:0]     comma_a_o,
   output logic [15:0]     comma_b_o
);
   import sdwa_pkg::*;
   logic [1:0] idx;
   logic       ref_q;
   logic       a_q;
   logic       b_q;
   //=======================================================================
   // comma then three data words; change just after a rise, steady at the next
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         ref_q <= 1'b0;
         idx <= 2'h0;
         tx_word_o <= K28_5_NEG;
      end
      else
      begin
         ref_q <= tx_ref_clock_i;
         if (tx_ref_clock_i && !ref_q)
         begin
            idx <= idx + 2'h1;
            tx_word_o <= (idx == 2'h3) ? K28_5_NEG : ((idx == 2'h1) ? 10'h155 : 10'h2AA);
         end
      end
   //=======================================================================
   // words are taken on the rise of either byte clock
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         a_q <= 1'b1;
         b_q <= 1'b0;
         comma_a_o <= 16'h0000;
         comma_b_o <= 16'h0000;
      end
      else
      begin
         a_q <= rx_clock_a_i;
         b_q <= rx_clock_b_i;
         if (rx_clock_a_i && !a_q && rx_word_i == K28_5_NEG)
            comma_a_o <= comma_a_o + 16'h0001;
         if (rx_clock_b_i && !b_q && rx_word_i == K28_5_NEG)
            comma_b_o <= comma_b_o + 16'h0001;
      end
endmodule

// file: sdwa_top_tb_top.sv
// self-checking bench: serial loopback, controller model, register traffic
`timescale 1ns/1ps
module sdwa_top_tb_top;
   import sdwa_pkg::*;
   logic        clk_i, resetn_i, serial_in_pos_i, serial_in_neg_i, flip, sync_q;
   logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
   logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic        tx_ref_clock_o, serial_out_o, rx_byte_clock_a_o, rx_byte_clock_b_o, sync_pass_o;
   logic [3:0]  s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd_v, c0;
   logic [9:0]  tx_parallel_word_i, rx_parallel_word_o;
   logic [15:0] comma_a, comma_b;
   int          fails, checks_done, srise, n_s, n_a, n_b;
   sdwa_top u_sdwa_top (.*);
   sdwa_mac_model u_sdwa_mac_model
   (
      .clk_i          (clk_i),
      .resetn_i       (resetn_i),
      .tx_ref_clock_i (tx_ref_clock_o),
      .rx_word_i      (rx_parallel_word_o),
      .rx_clock_a_i   (rx_byte_clock_a_o),
      .rx_clock_b_i   (rx_byte_clock_b_o),
      .tx_word_o      (tx_parallel_word_i),
      .comma_a_o      (comma_a),
      .comma_b_o      (comma_b)
   );
   //=======================================================================
   // clock, watchdog, loopback line with one-shot bit error, sync counting
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial
   begin
      #400000;
      fails++;
      complete_run;
   end
   always @(posedge clk_i)
   begin
      sync_q <= sync_pass_o;
      if (sync_pass_o && !sync_q)
         srise <= srise + 1;
      serial_in_pos_i <= serial_out_o ^ flip;
      serial_in_neg_i <= ~(serial_out_o ^ flip);
   end
   //=======================================================================
   // tasks
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("unexpected %s: expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_wstrb_i <= s;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do @(posedge clk_i); while (s_axi_awready_o !== 1'b1 || s_axi_wready_o !== 1'b1);
      s_axi_awvalid_i <= 1'b0;
      s_axi_wvalid_i <= 1'b0;
      do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
      s_axi_bready_i <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
   endtask
   task rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
      s_axi_arvalid_i <= 1'b0;
      do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
      s_axi_rready_i <= 1'b0;
      d = s_axi_rdata_o;
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
   endtask
   // comma every 40 bits, so a 400-cycle window holds exactly ten
   task win;
      int s0, a0, b0;
      s0 = srise;
      a0 = comma_a;
      b0 = comma_b;
      repeat (400) @(posedge clk_i);
      n_s = srise - s0;
      n_a = comma_a - a0;
      n_b = comma_b - b0;
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   //=======================================================================
   // test sequence
   initial
   begin
      resetn_i = 1'b0;
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h00;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i} = 12'h000;
      s_axi_wdata_i = 32'h0;
      {serial_in_pos_i, serial_in_neg_i, flip} = 3'h2;
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(CTRL_OFS, RESP_OKAY, rd_v);
      chk("ctrl reset", 32'h1, rd_v);
      rd(4'hC, RESP_SLVERR, rd_v);
      chk("unmapped", 32'h0, rd_v);
      wr(STAT_OFS, 32'h0, 4'hF, RESP_SLVERR);
      wr(CTRL_OFS, 32'h0, 4'h0, RESP_OKAY);
      rd(CTRL_OFS, RESP_OKAY, rd_v);
      chk("ctrl kept", 32'h1, rd_v);
      $display("test registers done");
      repeat (300) @(posedge clk_i);
      rd(STAT_OFS, RESP_OKAY, rd_v);
      chk("align state", 32'h6, rd_v & 32'h6);
      rd(COUNT_OFS, RESP_OKAY, c0);
      win();
      chk("sync pulses", 32'd10, n_s);
      chk("comma on b", 32'd10, n_b);
      chk("comma on a", 32'd0, n_a);
      rd(COUNT_OFS, RESP_OKAY, rd_v);
      chk("count step", 32'h1, {31'h0, (rd_v - c0) inside {[10:11]}});
      $display("test alignment done");
      wr(CTRL_OFS, 32'h0, 4'h1, RESP_OKAY);
      repeat (20) @(posedge clk_i);
      win();
      chk("sync off", 32'd0, n_s);
      wr(CTRL_OFS, 32'h1, 4'h1, RESP_OKAY);
      repeat (100) @(posedge clk_i);
      win();
      chk("sync back", 32'd10, n_s);
      $display("test align enable done");
      wr(CTRL_OFS, 32'h2, 4'h1, RESP_OKAY);
      repeat (300) @(posedge clk_i);
      chk("pass", 32'h1, {31'h0, sync_pass_o});
      // latch only once the checker sees a clean sequence, not the data it replaced
      wr(CTRL_OFS, 32'h3, 4'h1, RESP_OKAY);
      repeat (100) @(posedge clk_i);
      chk("latched pass", 32'h1, {31'h0, sync_pass_o});
      flip <= 1'b1;
      @(posedge clk_i);
      flip <= 1'b0;
      repeat (300) @(posedge clk_i);
      chk("latched fail", 32'h0, {31'h0, sync_pass_o});
      rd(STAT_OFS, RESP_OKAY, rd_v);
      chk("status fail", 32'h0, rd_v & 32'h9);
      wr(CTRL_OFS, 32'h2, 4'h1, RESP_OKAY);
      repeat (300) @(posedge clk_i);
      chk("live pass", 32'h1, {31'h0, sync_pass_o});
      wr(CTRL_OFS, 32'h1, 4'h1, RESP_OKAY);
      $display("test pattern done");
      complete_run;
   end
endmodule
